// file: srh_ctrl.sv
// host controller driving a 32k x 8 asynchronous sram
`timescale 1ns/100ps
`include "srh_regs.svh"
module srh_ctrl #(
  parameter int ADDR_W = `SRH_ADDR_W,
  parameter int DATA_W = `SRH_DATA_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic retain_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic retain_ok,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_cs_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [DATA_W-1:0] mem_dq_i
);
  // ****************************************************************
  // state
  // ****************************************************************
  srh_pkg::srh_state_t state_r;
  logic [`SRH_CNT_W-1:0] cnt_r;
  logic retain_s1_r;
  logic retain_s2_r;
  logic retain_s3_r;
  logic retain_lvl_r;
  logic [DATA_W-1:0] dq_s1_r;
  logic [DATA_W-1:0] dq_s2_r;
  logic [DATA_W-1:0] dq_s3_r;
  logic [DATA_W-1:0] dq_lvl_r;
  logic cnt_done;

  assign cnt_done = (cnt_r == `SRH_CNT_ZERO);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // retention request may come from power logic, treat as asynchronous
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      retain_s1_r <= 1'b0;
      retain_s2_r <= 1'b0;
      retain_s3_r <= 1'b0;
      retain_lvl_r <= 1'b0;
    end
    else
    begin
      retain_s1_r <= retain_req;
      retain_s2_r <= retain_s1_r;
      retain_s3_r <= retain_s2_r;
      if (retain_s2_r == retain_s3_r)
        retain_lvl_r <= retain_s3_r;
    end
  end

  // read data comes back from the pins, three stages and a settle check
  // costs latency, but a bus caught mid-change is never taken
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      dq_s3_r <= '0;
      dq_lvl_r <= '0;
    end
    else
    begin
      dq_s1_r <= mem_dq_i;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
      if (dq_s2_r == dq_s3_r)
        dq_lvl_r <= dq_s3_r;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= srh_pkg::SRH_IDLE;
      cnt_r <= `SRH_CNT_ZERO;
    end
    else
    begin
      if (!cnt_done)
        cnt_r <= cnt_r - `SRH_CNT_ONE;
      case (state_r)
        srh_pkg::SRH_IDLE:
        begin
          if (retain_lvl_r)
            state_r <= srh_pkg::SRH_SLEEP;
          else if (req_valid && req_write)
            state_r <= srh_pkg::SRH_WR_SETUP;
          else if (req_valid)
            state_r <= srh_pkg::SRH_RD_SETUP;
        end
        srh_pkg::SRH_RD_SETUP:
        begin
          // address settled one cycle before select falls
          state_r <= srh_pkg::SRH_RD_WAIT;
          cnt_r <= `SRH_CNT_W'(`SRH_RD_WAIT_CYC);
        end
        srh_pkg::SRH_RD_WAIT:
        begin
          if (cnt_done)
          begin
            state_r <= srh_pkg::SRH_TURN;
            cnt_r <= `SRH_CNT_W'(`SRH_TURN_CYC);
          end
        end
        srh_pkg::SRH_WR_SETUP:
        begin
          state_r <= srh_pkg::SRH_WR_PULSE;
          cnt_r <= `SRH_CNT_W'(`SRH_WP_LOAD_CYC);
        end
        srh_pkg::SRH_WR_PULSE:
        begin
          if (cnt_done)
            state_r <= srh_pkg::SRH_WR_END;
        end
        srh_pkg::SRH_WR_END:
          state_r <= srh_pkg::SRH_IDLE;
        srh_pkg::SRH_TURN:
        begin
          if (cnt_done)
            state_r <= srh_pkg::SRH_IDLE;
        end
        srh_pkg::SRH_SLEEP:
        begin
          if (!retain_lvl_r)
          begin
            state_r <= srh_pkg::SRH_TURN;
            cnt_r <= `SRH_CNT_W'(`SRH_RET_CYC);
          end
        end
        default:
          state_r <= srh_pkg::SRH_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  // all strobes registered so the pins never glitch
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mem_addr <= '0;
      mem_cs_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_dq_o <= '0;
      mem_dq_oe <= 1'b0;
    end
    else
    begin
      case (state_r)
        srh_pkg::SRH_IDLE:
        begin
          mem_cs_n <= 1'b1;
          mem_we_n <= 1'b1;
          mem_oe_n <= 1'b1;
          mem_dq_oe <= 1'b0;
          // address moves only while both strobes are high
          if (req_valid && !retain_lvl_r)
          begin
            mem_addr <= req_addr;
            mem_dq_o <= req_wdata;
          end
        end
        srh_pkg::SRH_RD_SETUP:
        begin
          mem_cs_n <= 1'b0;
          mem_we_n <= 1'b1;
          mem_oe_n <= 1'b0;
        end
        srh_pkg::SRH_WR_SETUP:
        begin
          // select and write enable fall together so outputs stay floating
          mem_cs_n <= 1'b0;
          mem_we_n <= 1'b0;
          mem_oe_n <= 1'b1;
          mem_dq_oe <= 1'b1;
        end
        srh_pkg::SRH_WR_PULSE:
        begin
          if (cnt_done)
          begin
            mem_we_n <= 1'b1;
            mem_cs_n <= 1'b1;
          end
        end
        srh_pkg::SRH_WR_END:
          mem_dq_oe <= 1'b0;
        srh_pkg::SRH_RD_WAIT:
        begin
          if (cnt_done)
          begin
            mem_cs_n <= 1'b1;
            mem_oe_n <= 1'b1;
          end
        end
        srh_pkg::SRH_SLEEP:
        begin
          mem_cs_n <= 1'b1;
          mem_we_n <= 1'b1;
          mem_oe_n <= 1'b1;
          mem_dq_oe <= 1'b0;
        end
        default:
        begin
          mem_cs_n <= mem_cs_n;
        end
      endcase
    end
  end

  // ****************************************************************
  // user side
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      retain_ok <= 1'b0;
    end
    else
    begin
      req_ready <= (state_r == srh_pkg::SRH_TURN && cnt_done) || (state_r == srh_pkg::SRH_WR_END);
      if (state_r == srh_pkg::SRH_IDLE && (req_valid || retain_lvl_r))
        req_ready <= 1'b0;
      else if (state_r == srh_pkg::SRH_IDLE)
        req_ready <= 1'b1;
      rsp_valid <= (state_r == srh_pkg::SRH_RD_WAIT) && cnt_done;
      // sampled after the synchroniser delay, past the access time
      if (state_r == srh_pkg::SRH_RD_WAIT && cnt_done)
        rsp_rdata <= dq_lvl_r;
      retain_ok <= (state_r == srh_pkg::SRH_SLEEP);
    end
  end
endmodule

// file: srh_mem_model.sv
// behavioural model of the 32k x 8 static ram
`timescale 1ns/100ps
module srh_mem_model (
  input logic [14:0] addr,
  input logic cs_n,
  input logic we_n,
  input logic oe_n,
  input logic [7:0] dq_in,
  output logic [7:0] dq_out
);
  // ****
  // array and pins
  // ****
  logic [7:0] mem_r [0:32767];
  logic [7:0] last_r = 8'h00;
  logic drv;
  // level store: whole overlap of both strobes is the write window
  always @(cs_n or we_n or addr or dq_in)
    if (!cs_n && !we_n)
      mem_r[addr] = dq_in;
  assign drv = !cs_n && we_n && !oe_n;
  // released pins show the inverse of the last value, never a kind default
  assign #20 dq_out = drv ? mem_r[addr] : ~last_r;
  always @(dq_out)
    if (drv)
      last_r = dq_out;
endmodule

// file: srh_pkg.sv
// types for the sram host controller
package srh_pkg;
  typedef enum logic [2:0] {
    SRH_IDLE,
    SRH_RD_SETUP,
    SRH_RD_WAIT,
    SRH_WR_SETUP,
    SRH_WR_PULSE,
    SRH_WR_END,
    SRH_TURN,
    SRH_SLEEP
  } srh_state_t;
endpackage

// file: srh_props.sv
// assertion checker for the sram host controller pins and user side handshake
`timescale 1ns/100ps
module srh_props (
  input logic clk,
  input logic srst,
  input logic req_ready,
  input logic rsp_valid,
  input logic retain_ok,
  input logic [14:0] mem_addr,
  input logic mem_cs_n,
  input logic mem_we_n,
  input logic mem_oe_n,
  input logic [7:0] mem_dq_o,
  input logic mem_dq_oe
);
  // ****
  // strobe, data pin, response and retention handshake checks
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence wr_pulse;
    (!mem_we_n && !mem_cs_n) [*3];
  endsequence
  sequence turn_wait;
    (!req_ready && mem_cs_n) [*3];
  endsequence
  a_addr_quiet: assert property (!$stable(mem_addr) |->
    (mem_cs_n || mem_we_n) && ($past(mem_cs_n) || $past(mem_we_n))) else $error("addr moved in write");
  a_read_we_high: assert property (!mem_oe_n |-> mem_we_n) else $error("we low in read");
  a_no_contend: assert property (mem_dq_oe |-> mem_oe_n) else $error("bus contention");
  a_addr_before_cs: assert property ($fell(mem_cs_n) |-> $stable(mem_addr)) else $error("late addr");
  a_write_width: assert property ($fell(mem_we_n) |-> wr_pulse) else $error("short write");
  a_data_steady: assert property (!mem_we_n |-> mem_dq_oe && $stable(mem_dq_o)) else $error("data moved");
  a_write_recov: assert property ($rose(mem_we_n) |-> mem_dq_oe && $stable(mem_dq_o)) else $error("no hold");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("long rsp");
  a_read_answer: assert property ($fell(mem_oe_n) |-> ##[3:10] rsp_valid) else $error("no rsp");
  a_retain_quiet: assert property (retain_ok |-> mem_cs_n && mem_we_n && !mem_dq_oe) else $error("not idle");
  a_retain_exit: assert property ($fell(retain_ok) |-> turn_wait) else $error("early access");
endmodule

// file: srh_regs.svh
// timing constants and field sizes for the sram host controller
`ifndef SRH_REGS_SVH
`define SRH_REGS_SVH
// ****************************************************************
// Functional notes
// - the host keeps write enable or chip select high whenever the address changes.
// - with output enable low during a write the pulse must cover output float time plus data setup.
// - write recovery is timed from the first of chip select or write enable to rise.
// - write enable stays high through every read cycle.
// - the host never drives the data pins while the memory may be driving them.
// - the address is valid no later than chip select falling for a read.
// - before retention the host deselects with chip select at the cmos high level, supply at least 2.0 V.
// - after retention the host waits one read cycle time before accesses.
// ****************************************************************
`define SRH_CLK_NS 8
`define SRH_TRC_NS 20
`define SRH_TAA_NS 20
`define SRH_TWP_NS 15
`define SRH_TWHZ_NS 10
`define SRH_TDW_NS 8
`define SRH_TOHZ_NS 8
`define SRH_TWR_NS 0
`define SRH_CYC_UP(ns) (((ns) + `SRH_CLK_NS - 1) / `SRH_CLK_NS)
`define SRH_RD_CYC (`SRH_CYC_UP(`SRH_TAA_NS) + 1)
`define SRH_WP_CYC `SRH_CYC_UP(`SRH_TWHZ_NS + `SRH_TDW_NS)
`define SRH_TURN_CYC `SRH_CYC_UP(`SRH_TOHZ_NS)
`define SRH_RET_CYC `SRH_CYC_UP(`SRH_TRC_NS)
`define SRH_RD_WAIT_CYC (`SRH_RD_CYC + 2)
`define SRH_WP_LOAD_CYC (`SRH_WP_CYC - 1)
`define SRH_ADDR_W 15
`define SRH_DATA_W 8
`define SRH_CNT_W 4
`define SRH_CNT_ONE 4'h1
`define SRH_CNT_ZERO 4'h0
`endif

// file: tb.sv
// self-checking bench for the sram host controller
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t %0h %0h", $time, a, b); end end
module tb;
  // ****
  // bench
  // ****
  logic clk = 0, srst = 1, req_valid = 0, req_write = 0, retain_req = 0;
  logic [14:0] req_addr = 15'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, retain_ok, mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe;
  logic [14:0] mem_addr;
  logic [7:0] rsp_rdata, mem_dq_o, m_out, dq;
  int n_fail = 0, n_tests = 0;
  assign dq = mem_dq_oe ? mem_dq_o : m_out;
  initial forever #4 clk = ~clk;
  srh_ctrl srh_ctrl_i (.clk(clk), .srst(srst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .retain_req(retain_req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retain_ok(retain_ok), .mem_addr(mem_addr),
    .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_o(mem_dq_o),
    .mem_dq_oe(mem_dq_oe), .mem_dq_i(dq));
  srh_mem_model srh_mem_model_i (.addr(mem_addr), .cs_n(mem_cs_n), .we_n(mem_we_n),
    .oe_n(mem_oe_n), .dq_in(mem_dq_o), .dq_out(m_out));
  task automatic finish_test();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic lim(input int i);
    if (i >= 40)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  // request held until the controller takes it
  task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
    int i;
    @(negedge clk);
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    for (i = 0; i < 40 && req_ready !== 1'b1; i++)
      @(negedge clk);
    lim(i);
    @(negedge clk);
    req_valid = 0;
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] q);
    int i;
    req(1'b0, a, 8'h00);
    for (i = 0; i < 40 && rsp_valid !== 1'b1; i++)
      @(negedge clk);
    lim(i);
    q = rsp_rdata;
  endtask
  task automatic t_rw();
    logic [7:0] q;
    req(1'b1, 15'h0000, 8'h55);
    req(1'b1, 15'h7FFF, 8'hA3);
    req(1'b1, 15'h0000, 8'h3C);
    rd(15'h7FFF, q);
    `CHK(q, 8'hA3)
    rd(15'h0000, q);
    `CHK(q, 8'h3C)
  endtask
  task automatic t_retain();
    int i;
    logic [7:0] q;
    retain_req = 1;
    for (i = 0; i < 40 && retain_ok !== 1'b1; i++)
      @(negedge clk);
    lim(i);
    `CHK(mem_cs_n, 1'b1)
    `CHK(req_ready, 1'b0)
    retain_req = 0;
    rd(15'h0000, q);
    `CHK(q, 8'h3C)
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    `CHK({mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe}, 4'hE)
    srst = 0;
    t_rw();
    t_retain();
    finish_test();
  end
endmodule
bind srh_ctrl srh_props srh_props_i (.clk(clk), .srst(srst), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .retain_ok(retain_ok), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
  .mem_oe_n(mem_oe_n), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
